/* File: design/ceds_pkg.sv */
// Shared constants and types of the channel enable delay sequencer.
package ceds_pkg;

  // Number of independent paths and their slots.
  localparam int CEDS_NUM_CH = 4;
  localparam int CEDS_CH_TX_ONE = 0;
  localparam int CEDS_CH_TX_TWO = 1;
  localparam int CEDS_CH_RX_ONE = 2;
  localparam int CEDS_CH_RX_TWO = 3;

  // Width of each programmed delay in clock cycles.
  localparam int CEDS_DLY_W = 16;
  // Counter width, two bits above the delays so sums never wrap.
  localparam int CEDS_CNT_W = CEDS_DLY_W + 2;

  // Clock rate and the analog power-up time without PLL retuning.
  localparam int CEDS_CLK_HZ = 40_000_000;
  localparam int CEDS_SETUP_US = 8;
  // Least time, so it rounds up to whole cycles.
  localparam int CEDS_SETUP_CYC =
    (CEDS_SETUP_US * (CEDS_CLK_HZ / 1000) + 999) / 1000;

  // Register byte offsets.
  localparam logic [11:0] CEDS_CTRL_OFS = 12'h000;
  localparam logic [11:0] CEDS_STATUS_OFS = 12'h004;
  localparam logic [11:0] CEDS_DLY_BASE = 12'h040;
  localparam logic [11:0] CEDS_DLY_END = 12'h0C0;
  // Delay word index within a channel block of eight words.
  localparam logic [2:0] CEDS_F_RISE_ON = 3'h0;
  localparam logic [2:0] CEDS_F_RISE_ANA = 3'h1;
  localparam logic [2:0] CEDS_F_GUARD = 3'h2;
  localparam logic [2:0] CEDS_F_HOLD = 3'h3;
  localparam logic [2:0] CEDS_F_FALL_OFF = 3'h4;

  // Control field positions.
  localparam int CEDS_CTRL_PRIMED_LSB = 0;
  localparam int CEDS_CTRL_SPI_MODE_LSB = 4;
  localparam int CEDS_CTRL_SPI_REQ_LSB = 8;
  // Status field positions.
  localparam int CEDS_ST_ANA_LSB = 8;
  localparam int CEDS_ST_EXT_LSB = 12;
  localparam int CEDS_ST_DATA_LSB = 16;

  // Reset values.
  localparam logic [CEDS_DLY_W-1:0] CEDS_DLY_RST = 16'h0000;
  localparam logic [3:0] CEDS_CTRL_RST = 4'h0;

  // Sequencer states, Gray coded along idle, rise, on, fall.
  typedef enum logic [1:0] {
    CEDS_IDLE = 2'b00,
    CEDS_RISE = 2'b01,
    CEDS_ON = 2'b11,
    CEDS_FALL = 2'b10
  } ceds_state_t;

  // Delay set of one channel.
  typedef struct packed {
    logic [CEDS_DLY_W-1:0] rise_on;
    logic [CEDS_DLY_W-1:0] rise_ana;
    logic [CEDS_DLY_W-1:0] guard;
    logic [CEDS_DLY_W-1:0] hold;
    logic [CEDS_DLY_W-1:0] fall_off;
  } ceds_dly_t;

  // Controls that one channel drives.
  typedef struct packed {
    logic ana;
    logic ext;
    logic data;
  } ceds_path_t;

endpackage

/* File: design/ceds_chan_seq.sv */
// One path's delayed enable sequencer.
`timescale 1ns/1ps
`default_nettype none
module ceds_chan_seq
  import ceds_pkg::*;
#(
  parameter bit IS_TX = 1'b1,
  parameter int SETUP_CYC = CEDS_SETUP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire ceds_dly_t cfg,
  input wire logic req,
  output ceds_path_t path,
  output ceds_state_t state
);

  // Whole state of the channel.
  typedef struct packed {
    ceds_state_t st;
    logic [CEDS_CNT_W-1:0] cnt;
    ceds_dly_t dly;
    logic req_q;
    ceds_path_t out;
  } ceds_chan_t;

  ceds_chan_t chan_reg;
  ceds_chan_t chan_next;

  // Widened delays and the end of analog power-up.
  logic [CEDS_CNT_W-1:0] t_on;
  logic [CEDS_CNT_W-1:0] t_ana;
  logic [CEDS_CNT_W-1:0] t_setup;
  logic [CEDS_CNT_W-1:0] t_hold;
  logic [CEDS_CNT_W-1:0] t_off;
  logic rise;
  logic fall;

  assign t_on = {2'b00, chan_reg.dly.rise_on};
  assign t_ana = {2'b00, chan_reg.dly.rise_ana};
  assign t_setup = t_ana + CEDS_CNT_W'(SETUP_CYC);
  assign t_hold = {2'b00, chan_reg.dly.hold};
  // Receive paths use their hold delay as the fall-to-off delay.
  assign t_off = IS_TX ? {2'b00, chan_reg.dly.fall_off} : t_hold;
  assign rise = req & ~chan_reg.req_q;
  assign fall = ~req & chan_reg.req_q;

  // Next state; the counter runs from the detected edge.
  always_comb begin
    chan_next = chan_reg;
    chan_next.req_q = req;
    // Delays are copied only when the channel is primed.
    if (load) begin
      chan_next.dly = cfg;
    end
    if (&chan_reg.cnt == 1'b0) begin
      chan_next.cnt = chan_reg.cnt + 1'b1;
    end
    // A fresh edge abandons any pending count.
    if (rise) begin
      chan_next.st = CEDS_RISE;
      chan_next.cnt = '0;
      chan_next.out.data = 1'b1;
    end else if (fall) begin
      chan_next.st = CEDS_FALL;
      chan_next.cnt = '0;
    end else begin
      case (chan_reg.st)
        CEDS_RISE: begin
          // Analog power-up starts after its own delay.
          if (chan_reg.cnt >= t_ana) begin
            chan_next.out.ana = 1'b1;
          end
          // Switch or LNA waits for its delay and for power-up.
          if (chan_reg.cnt >= t_on && chan_reg.cnt >= t_setup) begin
            chan_next.out.ext = 1'b1;
            chan_next.st = CEDS_ON;
          end
        end
        CEDS_FALL: begin
          // Data keeps flowing for the hold delay.
          if (chan_reg.cnt >= t_hold) begin
            chan_next.out.data = 1'b0;
          end
          // Switch back and analog down after fall-to-off.
          if (chan_reg.cnt >= t_off) begin
            chan_next.out.ext = 1'b0;
            chan_next.out.ana = 1'b0;
          end
          if (chan_reg.cnt >= t_hold && chan_reg.cnt >= t_off) begin
            chan_next.st = CEDS_IDLE;
          end
        end
        default: begin
          // Idle and on wait for the next edge.
          chan_next.st = chan_reg.st;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      chan_reg <= '{st: CEDS_IDLE, cnt: '0,
                    dly: '{CEDS_DLY_RST, CEDS_DLY_RST, CEDS_DLY_RST,
                           CEDS_DLY_RST, CEDS_DLY_RST},
                    req_q: 1'b0, out: '0};
    end else begin
      chan_reg <= chan_next;
    end
  end

  assign path = chan_reg.out;
  assign state = chan_reg.st;

endmodule
`default_nettype wire

/* File: design/ceds_top.sv */
// Four-path enable delay sequencer with its AHB-Lite register slave.
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ceds_top
  import ceds_pkg::*;
#(
  parameter int SETUP_CYC = CEDS_SETUP_CYC
) (
  input wire logic CLOCK,
  input wire logic RESET,
  // AHB-Lite slave.
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Path requests from the baseband.
  input wire logic TX_PATH_ONE_REQUEST,
  input wire logic TX_PATH_TWO_REQUEST,
  input wire logic RX_PATH_ONE_REQUEST,
  input wire logic RX_PATH_TWO_REQUEST,
  // Antenna switch to transmit, one per transmit path.
  output logic [1:0] TX_ANT_SWITCH,
  // External LNA power, one per receive path.
  output logic [1:0] RX_LNA_ON,
  // Analog front-end power, index per channel slot.
  output logic [3:0] ANALOG_POWER,
  // Data interface enable (unmask), index per channel slot.
  output logic [3:0] DATA_ENABLE
);

  // Whole register-side state.
  typedef struct packed {
    logic [3:0] primed;
    logic [3:0] spi_mode;
    logic [3:0] spi_req;
    logic [3:0] load;
    ceds_dly_t [CEDS_NUM_CH-1:0] cfg;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic rd_wait;
    logic [11:0] rd_addr;
    logic [31:0] hrdata;
    logic hready;
  } ceds_top_t;

  ceds_top_t top_reg;
  ceds_top_t top_next;

  // Per-channel outputs and states from the sequencers.
  ceds_path_t [CEDS_NUM_CH-1:0] path;
  ceds_state_t [CEDS_NUM_CH-1:0] state;
  // Pin requests in channel order.
  logic [3:0] pin_req;
  // Request presented to each sequencer.
  logic [3:0] req;
  // An accepted address phase.
  logic take;
  // Status word assembled from the sequencers.
  logic [31:0] status;

  assign pin_req = {RX_PATH_TWO_REQUEST, RX_PATH_ONE_REQUEST,
                    TX_PATH_TWO_REQUEST, TX_PATH_ONE_REQUEST};
  assign take = HSEL & HTRANS[1] & HREADY;

  // Each primed channel follows its pin or its software request.
  always_comb begin
    for (int i = 0; i < CEDS_NUM_CH; i++) begin
      req[i] = top_reg.primed[i] &
               (top_reg.spi_mode[i] ? top_reg.spi_req[i] : pin_req[i]);
    end
  end

  // Status: two state bits per channel, then the live controls.
  always_comb begin
    status = '0;
    for (int i = 0; i < CEDS_NUM_CH; i++) begin
      status[2*i +: 2] = state[i];
      status[CEDS_ST_ANA_LSB + i] = path[i].ana;
      status[CEDS_ST_EXT_LSB + i] = path[i].ext;
      status[CEDS_ST_DATA_LSB + i] = path[i].data;
    end
  end

  // Read mux for one word address; unmapped words read zero.
  function automatic logic [31:0] rd_word(input logic [11:0] a,
                                          input ceds_top_t s,
                                          input logic [31:0] st);
    logic [1:0] ch;
    logic [31:0] v;
    // Slot blocks start at the delay base, so bit 6 is flipped back.
    ch = a[6:5] ^ 2'b10;
    v = '0;
    if (a == CEDS_CTRL_OFS) begin
      v[CEDS_CTRL_PRIMED_LSB +: 4] = s.primed;
      v[CEDS_CTRL_SPI_MODE_LSB +: 4] = s.spi_mode;
      v[CEDS_CTRL_SPI_REQ_LSB +: 4] = s.spi_req;
    end else if (a == CEDS_STATUS_OFS) begin
      v = st;
    end else if (a >= CEDS_DLY_BASE && a < CEDS_DLY_END) begin
      case (a[4:2])
        CEDS_F_RISE_ON: v[CEDS_DLY_W-1:0] = s.cfg[ch].rise_on;
        CEDS_F_RISE_ANA: v[CEDS_DLY_W-1:0] = s.cfg[ch].rise_ana;
        CEDS_F_GUARD: v[CEDS_DLY_W-1:0] = s.cfg[ch].guard;
        CEDS_F_HOLD: v[CEDS_DLY_W-1:0] = s.cfg[ch].hold;
        CEDS_F_FALL_OFF: v[CEDS_DLY_W-1:0] = s.cfg[ch].fall_off;
        default: v = '0;
      endcase
    end
    return v;
  endfunction

  // Bus slave and register file next state.
  always_comb begin
    logic [1:0] ch;
    // The delay base sets bit 6, so slot zero decodes as 2'b10 raw.
    ch = top_reg.wr_addr[6:5] ^ 2'b10;
    top_next = top_reg;
    top_next.load = '0;
    top_next.wr_pend = 1'b0;
    top_next.hready = 1'b1;
    // Write data phase: stores the word taken in the address phase.
    if (top_reg.wr_pend) begin
      if (top_reg.wr_addr == CEDS_CTRL_OFS) begin
        top_next.primed = HWDATA[CEDS_CTRL_PRIMED_LSB +: 4];
        top_next.spi_mode = HWDATA[CEDS_CTRL_SPI_MODE_LSB +: 4];
        top_next.spi_req = HWDATA[CEDS_CTRL_SPI_REQ_LSB +: 4];
        // Priming a channel hands it its delay set.
        top_next.load = HWDATA[CEDS_CTRL_PRIMED_LSB +: 4] & ~top_reg.primed;
      end else if (top_reg.wr_addr >= CEDS_DLY_BASE &&
                   top_reg.wr_addr < CEDS_DLY_END) begin
        case (top_reg.wr_addr[4:2])
          CEDS_F_RISE_ON: top_next.cfg[ch].rise_on = HWDATA[CEDS_DLY_W-1:0];
          CEDS_F_RISE_ANA: begin
            // Zero is the advised value for short paths.
            top_next.cfg[ch].rise_ana = HWDATA[CEDS_DLY_W-1:0];
          end
          CEDS_F_GUARD: begin
            // Stored and read back only; the sequencer ignores it.
            top_next.cfg[ch].guard = HWDATA[CEDS_DLY_W-1:0];
          end
          CEDS_F_HOLD: begin
            // Hold also covers guard data at the frame end.
            top_next.cfg[ch].hold = HWDATA[CEDS_DLY_W-1:0];
          end
          CEDS_F_FALL_OFF: begin
            top_next.cfg[ch].fall_off = HWDATA[CEDS_DLY_W-1:0];
          end
          default: begin
            top_next.wr_pend = 1'b0;
          end
        endcase
      end
    end
    // A read waits one cycle so that a write just before it is seen.
    if (top_reg.rd_wait) begin
      top_next.rd_wait = 1'b0;
      top_next.hrdata = rd_word(top_reg.rd_addr, top_next, status);
    end else if (take) begin
      if (HWRITE) begin
        top_next.wr_pend = 1'b1;
        top_next.wr_addr = {HADDR[11:2], 2'b00};
      end else begin
        top_next.rd_wait = 1'b1;
        top_next.rd_addr = {HADDR[11:2], 2'b00};
        top_next.hready = 1'b0;
      end
    end
  end

  // Register all slave state.
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      top_reg <= '{primed: CEDS_CTRL_RST, spi_mode: CEDS_CTRL_RST,
                   spi_req: CEDS_CTRL_RST, load: '0,
                   cfg: '0, wr_pend: 1'b0, wr_addr: '0, rd_wait: 1'b0,
                   rd_addr: '0, hrdata: '0, hready: 1'b1};
    end else begin
      top_reg <= top_next;
    end
  end

  // One independent sequencer per path, two transmit then two receive.
  // The 8 us setup count gates the switch and LNA.
  for (genvar g = 0; g < CEDS_NUM_CH; g++) begin : g_ch
    ceds_chan_seq #(
      .IS_TX(g < 2),
      .SETUP_CYC(SETUP_CYC)
    ) u_seq (
      .clk(CLOCK),
      .rst(RESET),
      .load(top_reg.load[g]),
      .cfg(top_reg.cfg[g]),
      .req(req[g]),
      .path(path[g]),
      .state(state[g])
    );
  end

  // Pin outputs come straight from the sequencer flip-flops.
  assign TX_ANT_SWITCH = {path[CEDS_CH_TX_TWO].ext, path[CEDS_CH_TX_ONE].ext};
  assign RX_LNA_ON = {path[CEDS_CH_RX_TWO].ext, path[CEDS_CH_RX_ONE].ext};
  assign ANALOG_POWER = {path[3].ana, path[2].ana, path[1].ana, path[0].ana};
  assign DATA_ENABLE = {path[3].data, path[2].data, path[1].data,
                        path[0].data};
  assign HRDATA = top_reg.hrdata;
  assign HREADYOUT = top_reg.hready;
  // Every transfer is answered OKAY.
  assign HRESP = 1'b0;

endmodule
`default_nettype wire

/* File: test/ceds_bb_model.sv */
// Baseband model that drives the four path requests as frames.
`timescale 1ns/1ps
`default_nettype none
module ceds_bb_model
  import ceds_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] go,
  input wire logic [15:0] len,
  output logic [3:0] req
);
  // Request levels and the high time left on each path.
  typedef struct packed {
    logic [3:0] req;
    logic [3:0][15:0] cnt;
  } ceds_bb_t;
  ceds_bb_t st_reg, st_next;

  // Every path keeps its own frame, so one never waits on another.
  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < CEDS_NUM_CH; i++) begin
      if (go[i]) begin
        st_next.req[i] = 1'b1;
        st_next.cnt[i] = len;
      end else if (st_reg.cnt[i] != 16'h0000) begin
        st_next.cnt[i] = st_reg.cnt[i] - 16'h0001;
        // The request drops once its high time has run out.
        if (st_reg.cnt[i] == 16'h0001) begin
          st_next.req[i] = 1'b0;
        end
      end
    end
  end

  // Registers the model state; reset parks every request low.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Held low in reset so the block never sees an unknown request.
  assign req = st_reg.req & {4{~rst}};
endmodule
`default_nettype wire

/* File: test/ceds_properties.sv */
// Port-level checks of the enable delay sequencer.
`timescale 1ns/1ps
`default_nettype none
module ceds_properties #(
  parameter int SETUP_CYC = 8
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic TX_PATH_ONE_REQUEST,
  input wire logic [1:0] TX_ANT_SWITCH,
  input wire logic [1:0] RX_LNA_ON,
  input wire logic [3:0] ANALOG_POWER,
  input wire logic [3:0] DATA_ENABLE
);
  // Cycles that slot zero has had analog power, saturating.
  typedef struct packed {
    logic [15:0] ana;
  } ceds_chk_t;
  ceds_chk_t h_reg, h_next;
  logic rd_go;

  // The count restarts whenever analog power drops.
  always_comb begin
    h_next = h_reg;
    if (!ANALOG_POWER[0]) begin
      h_next.ana = 16'h0000;
    end else if (h_reg.ana != 16'hFFFF) begin
      h_next.ana = h_reg.ana + 16'h0001;
    end
  end

  // Registers the helper count.
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      h_reg <= '0;
    end else begin
      h_reg <= h_next;
    end
  end

  assign rd_go = HSEL && HTRANS[1] && HREADY && !HWRITE;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);

  a_resp_okay: assert property (HRESP == 1'b0)
    else $error("bus response not okay");
  a_read_wait: assert property (rd_go |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");
  a_write_nowait: assert property (
    (HSEL && HTRANS[1] && HREADY && HWRITE) |=> HREADYOUT)
    else $error("write stalled");
  a_reset_quiet: assert property (disable iff (1'b0) RESET |=>
    HREADYOUT && ANALOG_POWER == 4'h0 && DATA_ENABLE == 4'h0 &&
    TX_ANT_SWITCH == 2'b00 && RX_LNA_ON == 2'b00)
    else $error("outputs active after reset");
  a_switch_needs_ana: assert property (
    (TX_ANT_SWITCH & ~ANALOG_POWER[1:0]) == 2'b00)
    else $error("switch on without analog power");
  a_lna_needs_ana: assert property (
    (RX_LNA_ON & ~ANALOG_POWER[3:2]) == 2'b00)
    else $error("lna on without analog power");
  a_setup_wait: assert property (
    $rose(TX_ANT_SWITCH[0]) |-> int'(h_reg.ana) >= SETUP_CYC)
    else $error("switch before analog power-up ended");
  a_rx_off_together: assert property (
    $fell(DATA_ENABLE[2]) |-> !RX_LNA_ON[0] && !ANALOG_POWER[2])
    else $error("lna outlived receive disable");
  a_tx_off_pair: assert property (
    $fell(TX_ANT_SWITCH[0]) |-> $fell(ANALOG_POWER[0]))
    else $error("switch return and power-down apart");
  a_data_from_req: assert property (
    $rose(DATA_ENABLE[0]) |-> $past(TX_PATH_ONE_REQUEST))
    else $error("interface enabled without request");

  c_switch_on: cover property ($rose(TX_ANT_SWITCH[0]));
  c_lna_off: cover property ($fell(RX_LNA_ON[0]));
  c_read: cover property (rd_go);
endmodule

bind ceds_top ceds_properties #(.SETUP_CYC(SETUP_CYC)) u_props (
  .CLOCK(CLOCK), .RESET(RESET), .HSEL(HSEL), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .TX_PATH_ONE_REQUEST(TX_PATH_ONE_REQUEST), .TX_ANT_SWITCH(TX_ANT_SWITCH),
  .RX_LNA_ON(RX_LNA_ON), .ANALOG_POWER(ANALOG_POWER),
  .DATA_ENABLE(DATA_ENABLE));
`default_nettype wire

/* File: test/test_channel_enable_delay_sequencer.sv */
// Self-checking bench for the four-path enable delay sequencer.
`timescale 1ns/1ps
`default_nettype none
module test_channel_enable_delay_sequencer
  import ceds_pkg::*;
;
  localparam int SETUP = 8;
  // One awaited change of an output bit; cycle -1 accepts any cycle.
  typedef struct {int c; logic v;} ceds_note_t;
  logic CLOCK = 1'b0, RESET = 1'b1, HSEL = 1'b0, HWRITE = 1'b0;
  logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, seed = 32'h0000000C;
  logic [1:0] HTRANS = 2'b00, TX_ANT_SWITCH, RX_LNA_ON;
  logic [3:0] ANALOG_POWER, DATA_ENABLE, req, go = 4'h0;
  logic HREADYOUT, HRESP, rd_ph = 1'b0;
  logic [15:0] len = 16'h0000;
  logic [11:0] cur, prev = 12'h000;
  logic [31:0] rd_q[$];
  ceds_note_t eq[12][$];
  ceds_note_t n;
  int ro[4], ra[4], hd[4], fo[4];
  int cyc = 0, error_cnt = 0, cmp_count = 0;

  ceds_top #(.SETUP_CYC(SETUP)) uut (
    .CLOCK(CLOCK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .TX_PATH_ONE_REQUEST(req[0]),
    .TX_PATH_TWO_REQUEST(req[1]), .RX_PATH_ONE_REQUEST(req[2]),
    .RX_PATH_TWO_REQUEST(req[3]), .TX_ANT_SWITCH(TX_ANT_SWITCH),
    .RX_LNA_ON(RX_LNA_ON), .ANALOG_POWER(ANALOG_POWER),
    .DATA_ENABLE(DATA_ENABLE));
  ceds_bb_model u_bb (.clk(CLOCK), .rst(RESET), .go(go), .len(len),
    .req(req));

  // The clock runs at 40 MHz; the cycle count dates every output change.
  always #12.5 CLOCK = ~CLOCK;
  always @(posedge CLOCK) cyc <= cyc + 1;

  // Compares one value and counts the outcome.
  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Xorshift source so every run programs the same delays.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // One single word transfer; a read notes its awaited data first.
  task automatic ahb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    if (!wr) rd_q.push_back(d);
    @(posedge CLOCK);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HWRITE <= wr;
    HADDR <= {20'h00000, a};
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= d;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
  endtask

  // Writes one delay with junk above it, then reads it back.
  task automatic wr_dly(input int c, input logic [2:0] f, input int v);
    logic [11:0] a;
    a = CEDS_DLY_BASE + 12'(c * 32) + {7'h00, f, 2'b00};
    ahb(1'b1, a, {16'hA5A5, 16'(v)});
    ahb(1'b0, a, {16'h0000, 16'(v)});
  endtask

  // Notes each change one path makes for a frame seen at edge e.
  task automatic plan(input int ch, input int e, input int l);
    int f, ta, te, tf;
    f = e + l;
    // Switch times assume propagation covers the internal path.
    ta = e + ra[ch] + 1;
    te = e + ((ro[ch] > ra[ch] + SETUP) ? ro[ch] : ra[ch] + SETUP) + 1;
    tf = (ch < 2) ? f + fo[ch] + 1 : f + hd[ch] + 1;
    eq[8 + ch].push_back('{-1, 1'b1});
    if (ta < f) eq[ch].push_back('{ta, 1'b1});
    if (te < f) eq[4 + ch].push_back('{te, 1'b1});
    eq[8 + ch].push_back('{f + hd[ch] + 1, 1'b0});
    if (ta < f) eq[ch].push_back('{tf, 1'b0});
    if (te < f) eq[4 + ch].push_back('{tf, 1'b0});
  endtask

  // Starts a frame of l cycles on the paths in m.
  task automatic frame(input logic [3:0] m, input int l, input bit pl);
    @(posedge CLOCK);
    go <= m;
    len <= 16'(l);
    for (int c = 0; c < 4; c++) if (m[c] && pl) plan(c, cyc + 3, l);
    @(posedge CLOCK);
    go <= 4'h0;
  endtask

  // Read data are compared as each read data phase completes.
  always @(posedge CLOCK) begin
    if (rd_ph && HREADYOUT) begin
      rd_ph <= 1'b0;
      check("hrdata", rd_q.pop_front(), HRDATA);
    end
    if (HSEL && HTRANS[1] && HREADYOUT && !HWRITE) rd_ph <= 1'b1;
  end

  // Each output change takes the oldest note of its own bit.
  always @(negedge CLOCK) begin
    cur = {DATA_ENABLE, RX_LNA_ON, TX_ANT_SWITCH, ANALOG_POWER};
    for (int b = 0; b < 12; b++) begin
      if (!RESET && cur[b] !== prev[b]) begin
        if (eq[b].size() == 0) begin
          check("unexpected change", 32'(b), 32'hFFFFFFFF);
        end else begin
          n = eq[b].pop_front();
          check("output level", {31'h0, n.v}, {31'h0, cur[b]});
          if (n.c >= 0) check("change cycle", n.c, cyc);
        end
      end
    end
    prev = cur;
  end

  // Main sequence: register defaults, unprimed requests, three passes.
  initial begin
    repeat (4) @(posedge CLOCK);
    RESET <= 1'b0;
    ahb(1'b0, CEDS_CTRL_OFS, 32'h0);
    ahb(1'b0, CEDS_DLY_BASE, 32'h0);
    ahb(1'b1, 12'h100, 32'h12345678);
    ahb(1'b0, 12'h100, 32'h0);
    frame(4'hF, 20, 1'b0);
    repeat (60) @(posedge CLOCK);
    $display("test defaults and unprimed done");
    for (int p = 0; p < 3; p++) begin
      ahb(1'b1, CEDS_CTRL_OFS, 32'h0);
      for (int c = 0; c < 4; c++) begin
        ro[c] = int'(rnd() % 32);
        ra[c] = (p == 1) ? 20 + int'(rnd() % 8) : int'(rnd() % 4);
        if (p == 0) ra[c] = 0;
        hd[c] = int'(rnd() % 8);
        fo[c] = int'(rnd() % 16);
        wr_dly(c, CEDS_F_RISE_ON, ro[c]);
        wr_dly(c, CEDS_F_RISE_ANA, ra[c]);
        wr_dly(c, CEDS_F_GUARD, 0);
        wr_dly(c, CEDS_F_HOLD, hd[c]);
        wr_dly(c, CEDS_F_FALL_OFF, fo[c]);
      end
      ahb(1'b1, CEDS_CTRL_OFS, 32'hF);
      ahb(1'b0, CEDS_CTRL_OFS, 32'hF);
      frame(4'hF, (p == 2) ? 6 : 60, 1'b1);
      repeat (150) @(posedge CLOCK);
      ahb(1'b0, CEDS_STATUS_OFS, 32'h0);
      $display("test pass %0d done", p);
    end
    // Software request on receive slot one; only order and level count.
    eq[10].push_back('{-1, 1'b1});
    eq[2].push_back('{-1, 1'b1});
    eq[6].push_back('{-1, 1'b1});
    ahb(1'b1, CEDS_CTRL_OFS, 32'h444);
    ahb(1'b0, CEDS_CTRL_OFS, 32'h444);
    repeat (100) @(posedge CLOCK);
    eq[10].push_back('{-1, 1'b0});
    eq[2].push_back('{-1, 1'b0});
    eq[6].push_back('{-1, 1'b0});
    ahb(1'b1, CEDS_CTRL_OFS, 32'h044);
    repeat (100) @(posedge CLOCK);
    ahb(1'b0, CEDS_STATUS_OFS, 32'h0);
    $display("test software mode done");
    for (int b = 0; b < 12; b++) check("pending", 0, eq[b].size());
    end_sim();
  end

  // Cuts a hang short; the tests need only about a thousand cycles.
  initial begin
    repeat (20000) @(posedge CLOCK);
    error_cnt++;
    $display("watchdog expired");
    end_sim();
  end
endmodule
`default_nettype wire
